/* File: rtl/plm_pkg.sv */
// Package: register map, field layout and reset values of the link mode registers
package plm_pkg;
  localparam logic [4:0] PLM_LINK_IDX = 5'h10;
  localparam logic [4:0] PLM_MODE_IDX = 5'h11;
  // Link control fields
  localparam int PLM_L_SPDOPT = 8;
  localparam int PLM_L_BRKTHR = 4;
  localparam int PLM_L_BRKEN = 3;
  localparam int PLM_L_PWROPT = 2;
  localparam int PLM_L_LOGIC_RESET_CTL = 0;
  // 10/100 mode fields
  localparam int PLM_M_SHORTED = 15;
  localparam int PLM_M_FAST10 = 14;
  localparam int PLM_M_EDPD = 13;
  localparam int PLM_M_EDNLP = 12;
  localparam int PLM_M_SPDEN = 7;
  localparam int PLM_M_NPEN = 6;
  localparam int PLM_M_XDIS = 5;
  localparam int PLM_M_ANPDIS = 4;
  localparam int PLM_M_ENERGY = 1;
  localparam int PLM_M_SEMIX = 0;
  // Reset values and writable masks
  localparam logic [15:0] PLM_LINK_RST = 16'h0020;
  localparam logic [15:0] PLM_MODE_RST = 16'h0040;
  localparam logic [15:0] PLM_LINK_WMASK = 16'h033D;
  localparam logic [15:0] PLM_MODE_WMASK = 16'hF0F1;
  localparam logic PLM_ENERGY_RST = 1'b1;
  // Attempts before speed downshift, per code
  localparam logic [2:0] PLM_ATT_00 = 3'h7;
  localparam logic [2:0] PLM_ATT_01 = 3'h5;
  localparam logic [2:0] PLM_ATT_10 = 3'h4;
  localparam logic [2:0] PLM_ATT_11 = 3'h3;

  typedef struct packed {
    logic [2:0] spd_attempts;
    logic [1:0] brk_thresh;
    logic brk_en;
    logic pwr_opt_dis;
    logic short_energy_detect;
    logic ten_meg_test_mode;
    logic energy_detect_powerdown_en;
    logic edpd_nlp;
    logic spd_opt_en;
    logic np_en;
    logic auto_x_dis;
    logic auto_np_dis;
    logic semi_x_en;
  } plm_cfg_t;

  typedef struct packed {
    logic [4:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } plm_req_t;
endpackage

/* File: rtl/plm_regs.sv */
// Link control and 10/100 mode control/status registers with decoded controls
`timescale 1ns/10ps
// What this block does
// - Bits 9:8 pick 7, 5, 4 or 3 failed attempts before downshift; reset 00.
// - Bits 5:4 pick idle-error link break threshold 10E-8..10E-11; reset 10.
// - Link break acts only while link control bit 3 is one; reset zero.
// - Link control bit 2 one disables automatic power optimization; reset zero.
// - Writing one to bit 0 gives synchronous logic reset, registers untouched.
// - The logic reset bit never clears itself.
// - Mode bit 15 selects short energy detection; reset zero.
// - Mode bit 14 enters 10BASE-T fast test mode; reset zero.
// - Energy-detect power-down enabled only while mode bit 13 is one.
// - Mode bit 12 keeps link pulses during energy-detect power-down; reset zero.
// - Speed optimizer runs only while mode bit 7 is one; reset zero.
// - Mode bit 6 enables next page exchange; resets to one.
// - Mode bit 5 one disables automatic crossover, manual pair choice.
// - Mode bit 4 stops automatic next pages; advertisement bit decides.
// - With bit 4 set and advertised next page clear, send base page only.
// - Read-only bit 1 shows line energy; hardware reset sets, software clears.
// - Energy one before software reset sets energy change flag for one cycle; it clears itself.
// - Mode bit 0 enables semi crossover; reset zero.
// - Manual MDI/MDI-X bits act only while automatic crossover is disabled.
module plm_regs
  import plm_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sw_reset_i,
  // Management register access
  input wire plm_req_t mgmt_req_i,
  output logic [15:0] mgmt_rdata_o,
  output logic mgmt_rvalid_o,
  // Line and negotiation status from the engines
  input wire logic line_energy_i,
  input wire logic adv_next_page_i,
  input wire logic [1:0] manual_mdix_i,
  input wire logic [1:0] auto_mdix_i,
  // Controls to the engines
  output plm_cfg_t cfg_o,
  output logic logic_reset_ctl_o,
  output logic line_energy_present_o,
  output logic energy_change_flag_set_o,
  output logic next_page_adv_o,
  output logic base_page_only_o,
  output logic [1:0] mdix_sel_o
);

  logic [15:0] link_r;
  logic [15:0] link_nxt;
  logic [15:0] mode_r;
  logic [15:0] mode_nxt;
  logic energy_r;
  logic energy_nxt;
  logic eflag_r;
  logic eflag_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic wr_link;
  logic wr_mode;
  logic [2:0] spd_att;

  assign wr_link = mgmt_req_i.wr && (mgmt_req_i.addr == PLM_LINK_IDX);
  assign wr_mode = mgmt_req_i.wr && (mgmt_req_i.addr == PLM_MODE_IDX);

  // Register write path; software reset restores defaults
  always_comb begin
    link_nxt = link_r;
    mode_nxt = mode_r;
    if (sw_reset_i) begin
      link_nxt = PLM_LINK_RST;
      mode_nxt = PLM_MODE_RST;
    end else begin
      if (wr_link) begin
        // Masked so reserved and read-only bits stay zero
        link_nxt = mgmt_req_i.wdata & PLM_LINK_WMASK;
      end
      if (wr_mode) begin
        mode_nxt = mgmt_req_i.wdata & PLM_MODE_WMASK;
      end
    end
  end

  // Logic reset bit is held as written, only a write of zero or a hardware or software reset drops it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_r <= PLM_LINK_RST;
      mode_r <= PLM_MODE_RST;
    end else if (ce_i) begin
      link_r <= link_nxt;
      mode_r <= mode_nxt;
    end
  end

  // Line energy status and energy change event
  always_comb begin
    energy_nxt = line_energy_i;
    eflag_nxt = 1'b0;
    if (sw_reset_i) begin
      energy_nxt = 1'b0;
      eflag_nxt = energy_r;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      energy_r <= PLM_ENERGY_RST;
      eflag_r <= 1'b0;
    end else if (ce_i) begin
      energy_r <= energy_nxt;
      eflag_r <= eflag_nxt;
    end
  end

  // Read path: one cycle latency, unmapped indices read zero
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = mgmt_req_i.rd;
    if (mgmt_req_i.rd) begin
      if (mgmt_req_i.addr == PLM_LINK_IDX) begin
        rdata_nxt = link_r;
      end else if (mgmt_req_i.addr == PLM_MODE_IDX) begin
        rdata_nxt = mode_r;
        rdata_nxt[PLM_M_ENERGY] = energy_r;
      end else begin
        rdata_nxt = 16'h0000;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else if (ce_i) begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign mgmt_rdata_o = rdata_r;
  assign mgmt_rvalid_o = rvalid_r;

  // Attempt count per downshift code
  always_comb begin
    case (link_r[PLM_L_SPDOPT +: 2])
      2'b00: spd_att = PLM_ATT_00;
      2'b01: spd_att = PLM_ATT_01;
      2'b10: spd_att = PLM_ATT_10;
      default: spd_att = PLM_ATT_11;
    endcase
  end
  assign cfg_o.spd_attempts = spd_att;

  assign cfg_o.brk_thresh = link_r[PLM_L_BRKTHR +: 2];
  assign cfg_o.brk_en = link_r[PLM_L_BRKEN];
  assign cfg_o.pwr_opt_dis = link_r[PLM_L_PWROPT];
  assign cfg_o.short_energy_detect = mode_r[PLM_M_SHORTED];
  assign cfg_o.ten_meg_test_mode = mode_r[PLM_M_FAST10];
  assign cfg_o.energy_detect_powerdown_en = mode_r[PLM_M_EDPD];
  assign cfg_o.edpd_nlp = mode_r[PLM_M_EDNLP];
  assign cfg_o.spd_opt_en = mode_r[PLM_M_SPDEN];
  assign cfg_o.np_en = mode_r[PLM_M_NPEN];
  assign cfg_o.auto_x_dis = mode_r[PLM_M_XDIS];
  assign cfg_o.auto_np_dis = mode_r[PLM_M_ANPDIS];
  assign cfg_o.semi_x_en = mode_r[PLM_M_SEMIX];

  // Held logic reset level, synchronous to the core clock
  assign logic_reset_ctl_o = link_r[PLM_L_LOGIC_RESET_CTL];
  assign line_energy_present_o = energy_r;
  assign energy_change_flag_set_o = eflag_r;

  // Next page advertising falls back to the advertisement bit
  assign next_page_adv_o = mode_r[PLM_M_ANPDIS] ? adv_next_page_i
                                                : mode_r[PLM_M_NPEN];
  assign base_page_only_o = mode_r[PLM_M_ANPDIS] & ~adv_next_page_i;

  // Manual pair selection only wins when auto crossover is off
  assign mdix_sel_o = mode_r[PLM_M_XDIS] ? manual_mdix_i : auto_mdix_i;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  spd_attempt_decode_a: assert property (
    (link_r[9:8] == 2'b00) |-> (cfg_o.spd_attempts == 3'h7)
  ) else $error("speed attempts not seven for code zero");

  link_write_take_a: assert property (
    (ce_i && !sw_reset_i && wr_link)
      |=> (cfg_o.brk_thresh == $past(mgmt_req_i.wdata[5:4]))
  ) else $error("threshold not taken from write");

  sw_reset_default_a: assert property (
    (ce_i && sw_reset_i) |=> (cfg_o.brk_thresh == 2'b10 && !cfg_o.brk_en
      && cfg_o.np_en && !cfg_o.auto_x_dis)
  ) else $error("defaults not restored by software reset");

  logic_reset_ctl_hold_a: assert property (
    (logic_reset_ctl_o && !(wr_link || sw_reset_i)) |=> logic_reset_ctl_o
  ) else $error("logic reset bit cleared itself");

  logic_reset_ctl_set_a: assert property (
    (ce_i && !sw_reset_i && wr_link && mgmt_req_i.wdata[0])
      |=> logic_reset_ctl_o ##1 (mode_r == $past(mode_r) || $past(wr_mode || sw_reset_i))
  ) else $error("logic reset not set or registers disturbed");

  reserved_zero_a: assert property (
    ((link_r & ~PLM_LINK_WMASK) == 16'h0000)
      && ((mode_r & ~PLM_MODE_WMASK) == 16'h0000)
  ) else $error("reserved bit not zero");

  energy_clear_a: assert property (
    (ce_i && sw_reset_i) |=> !line_energy_present_o
  ) else $error("line energy not cleared by software reset");

  energy_flag_a: assert property (
    (ce_i && sw_reset_i && energy_r) |=> energy_change_flag_set_o ##1
      (!energy_change_flag_set_o || $past(!ce_i || (sw_reset_i && energy_r)))
  ) else $error("energy change flag not raised once");

  base_page_a: assert property (
    (cfg_o.auto_np_dis && !adv_next_page_i)
      |-> (base_page_only_o && !next_page_adv_o)
  ) else $error("next page sent while base page only");

  manual_mdix_a: assert property (
    !cfg_o.auto_x_dis |-> (mdix_sel_o == auto_mdix_i)
  ) else $error("manual crossover used while auto enabled");

  read_mode_a: assert property (
    (ce_i && mgmt_req_i.rd && mgmt_req_i.addr == PLM_MODE_IDX)
      |=> (mgmt_rvalid_o && mgmt_rdata_o[1] == $past(energy_r))
  ) else $error("mode read lacks line energy");

  spd_attempt_map_a: assert property (
    cfg_o.spd_attempts == ((link_r[PLM_L_SPDOPT +: 2] == 2'b01) ? PLM_ATT_01
      : (link_r[PLM_L_SPDOPT +: 2] == 2'b10) ? PLM_ATT_10
      : (link_r[PLM_L_SPDOPT +: 2] == 2'b11) ? PLM_ATT_11 : PLM_ATT_00)
  ) else $error("speed attempts do not match the code");

  mode_write_take_a: assert property (
    (ce_i && !sw_reset_i && wr_mode)
      |=> (mode_r == ($past(mgmt_req_i.wdata) & PLM_MODE_WMASK))
  ) else $error("mode write not taken under its mask");

  mode_hold_a: assert property (
    !(ce_i && (wr_mode || sw_reset_i)) |=> $stable(mode_r)
  ) else $error("mode register changed without a write");

  ce_freeze_a: assert property (
    !ce_i |=> ($stable(link_r) && $stable(mode_r) && $stable(energy_r))
  ) else $error("state moved while clock enable low");

  logic_reset_ctl_clear_a: assert property (
    (ce_i && !sw_reset_i && wr_link && !mgmt_req_i.wdata[0]) |=> !logic_reset_ctl_o
  ) else $error("logic reset bit not dropped by a write of zero");

  energy_follow_a: assert property (
    (ce_i && !sw_reset_i) |=> (line_energy_present_o == $past(line_energy_i))
  ) else $error("line energy does not follow the detector");

  hw_reset_energy_a: assert property (
    $fell(rst_i) |-> (line_energy_present_o && !energy_change_flag_set_o
      && !logic_reset_ctl_o)
  ) else $error("hardware reset did not set line energy");

  flag_quiet_a: assert property (
    (ce_i && !(sw_reset_i && energy_r)) |=> !energy_change_flag_set_o
  ) else $error("energy change flag raised without cause");

  read_other_zero_a: assert property (
    (ce_i && mgmt_req_i.rd && mgmt_req_i.addr != PLM_LINK_IDX
      && mgmt_req_i.addr != PLM_MODE_IDX)
      |=> (mgmt_rvalid_o && mgmt_rdata_o == 16'h0000)
  ) else $error("unmapped index did not read zero");

  read_link_a: assert property (
    (ce_i && mgmt_req_i.rd && mgmt_req_i.addr == PLM_LINK_IDX)
      |=> (mgmt_rvalid_o && mgmt_rdata_o == $past(link_r))
  ) else $error("link read does not return the register");

  rvalid_pulse_a: assert property (
    (ce_i && !mgmt_req_i.rd) |=> !mgmt_rvalid_o
  ) else $error("read valid without a read");

  manual_used_a: assert property (
    cfg_o.auto_x_dis |-> (mdix_sel_o == manual_mdix_i)
  ) else $error("manual crossover ignored while auto disabled");

  next_page_norm_a: assert property (
    !cfg_o.auto_np_dis |-> (next_page_adv_o == cfg_o.np_en && !base_page_only_o)
  ) else $error("next page not driven by its enable");

  cov_logic_reset_ctl_c: cover property (
    (ce_i && wr_link && mgmt_req_i.wdata[0]) ##1 logic_reset_ctl_o [*3]
  );
  cov_flag_c: cover property (energy_change_flag_set_o);
  cov_manual_c: cover property (cfg_o.auto_x_dis && mdix_sel_o != auto_mdix_i);
  cov_base_c: cover property (base_page_only_o);
  cov_freeze_c: cover property (!ce_i ##1 ce_i);

endmodule

/* File: tb/plm_host.sv */
// Management host model that issues single register writes and reads
`timescale 1ns/10ps
module plm_host
  import plm_pkg::*;
(
  // Clock
  input wire logic core_clk_i,
  // Register access
  output plm_req_t req_o,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i
);
  initial req_o = '{addr: 5'h00, wr: 1'b0, rd: 1'b0, wdata: 16'h0000};
  // Idle address and data are inverted so a stale value never looks fresh
  task automatic access(input logic [4:0] a, input logic w, input logic [15:0] d);
    @(negedge core_clk_i);
    req_o = '{addr: a, wr: w, rd: ~w, wdata: d};
    @(negedge core_clk_i);
    req_o = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
  task automatic read(input logic [4:0] a, output logic [15:0] d);
    access(a, 1'b0, 16'h0000);
    d = rvalid_i ? rdata_i : 16'hXXXX;
  endtask
endmodule

/* File: tb/tb_phy_link_mode_control_regs.sv */
// Self-checking bench for the link control and 10/100 mode registers
`timescale 1ns/10ps
module tb_phy_link_mode_control_regs;
  import plm_pkg::*;
  logic core_clk_i, rst_i, ce_i, sw_reset_i, line_energy_i, adv_next_page_i;
  logic [1:0] manual_mdix_i, auto_mdix_i, mdix_sel_o;
  plm_req_t mgmt_req_i;
  plm_cfg_t cfg_o;
  logic [15:0] mgmt_rdata_o;
  logic mgmt_rvalid_o, logic_reset_ctl_o, line_energy_present_o, energy_change_flag_set_o;
  logic next_page_adv_o, base_page_only_o;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  plm_regs uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .sw_reset_i(sw_reset_i), .mgmt_req_i(mgmt_req_i), .mgmt_rdata_o(mgmt_rdata_o),
    .mgmt_rvalid_o(mgmt_rvalid_o), .line_energy_i(line_energy_i),
    .adv_next_page_i(adv_next_page_i), .manual_mdix_i(manual_mdix_i),
    .auto_mdix_i(auto_mdix_i), .cfg_o(cfg_o), .logic_reset_ctl_o(logic_reset_ctl_o),
    .line_energy_present_o(line_energy_present_o),
    .energy_change_flag_set_o(energy_change_flag_set_o), .next_page_adv_o(next_page_adv_o),
    .base_page_only_o(base_page_only_o), .mdix_sel_o(mdix_sel_o));
  plm_host host (.core_clk_i(core_clk_i), .req_o(mgmt_req_i), .rdata_i(mgmt_rdata_o),
    .rvalid_i(mgmt_rvalid_o));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.read(a, d);
    chk(d, exp);
  endtask
  task automatic t_defaults();
    rchk(PLM_LINK_IDX, 16'h0020);
    rchk(PLM_MODE_IDX, 16'h0042);
    chk(16'(cfg_o.spd_attempts), 16'h0007);
    chk(16'(logic_reset_ctl_o), 16'h0000);
    chk(cfg_o, 16'hF008);
    chk(16'(mdix_sel_o), 16'h0001);
    chk(16'(next_page_adv_o), 16'h0001);
  endtask
  task automatic t_freeze();
    @(negedge core_clk_i);
    ce_i = 1'b0;
    host.access(PLM_LINK_IDX, 1'b1, 16'h0101);
    chk(16'(logic_reset_ctl_o), 16'h0000);
    host.access(PLM_MODE_IDX, 1'b0, 16'h0000);
    chk(16'(mgmt_rvalid_o), 16'h0000);
    ce_i = 1'b1;
    rchk(PLM_LINK_IDX, 16'h0020);
  endtask
  task automatic t_hwreset();
    line_energy_i = 1'b0;
    host.access(PLM_LINK_IDX, 1'b1, 16'h0101);
    rst_i = 1'b1;
    @(negedge core_clk_i);
    chk(16'(line_energy_present_o), 16'h0001);
    chk(16'(logic_reset_ctl_o), 16'h0000);
    rst_i = 1'b0;
    @(negedge core_clk_i);
    chk(16'(line_energy_present_o), 16'h0000);
    rchk(PLM_LINK_IDX, 16'h0020);
  endtask
  task automatic t_speed();
    logic [2:0] att [4];
    att = '{3'h7, 3'h5, 3'h4, 3'h3};
    for (int i = 0; i < 4; i++) begin
      host.access(PLM_LINK_IDX, 1'b1, {6'h00, 2'(i), 8'h00});
      chk(16'(cfg_o.spd_attempts), 16'(att[i]));
    end
  endtask
  task automatic t_all_ones();
    host.access(PLM_LINK_IDX, 1'b1, 16'hFFFF);
    host.access(PLM_MODE_IDX, 1'b1, 16'hFFFF);
    host.access(5'h12, 1'b1, 16'hFFFF);
    rchk(PLM_LINK_IDX, 16'h033D);
    rchk(PLM_MODE_IDX, 16'hF0F3);
    rchk(5'h12, 16'h0000);
    chk(cfg_o, 16'h7FFF);
    repeat (6) @(negedge core_clk_i);
    chk(16'(logic_reset_ctl_o), 16'h0001);
    chk(16'(mdix_sel_o), 16'h0002);
    chk(16'(base_page_only_o), 16'h0001);
    chk(16'(next_page_adv_o), 16'h0000);
    adv_next_page_i = 1'b1;
    @(negedge core_clk_i);
    chk(16'(next_page_adv_o), 16'h0001);
    chk(16'(base_page_only_o), 16'h0000);
    adv_next_page_i = 1'b0;
    host.access(PLM_MODE_IDX, 1'b1, 16'h0040);
    chk(16'(mdix_sel_o), 16'h0001);
    chk(16'(next_page_adv_o), 16'h0001);
    chk(16'(base_page_only_o), 16'h0000);
  endtask
  task automatic t_swreset(input logic e);
    int cnt;
    line_energy_i = e;
    repeat (2) @(negedge core_clk_i);
    sw_reset_i = 1'b1;
    @(negedge core_clk_i);
    sw_reset_i = 1'b0;
    chk(16'(line_energy_present_o), 16'h0000);
    cnt = int'(energy_change_flag_set_o);
    repeat (2) @(negedge core_clk_i) cnt += int'(energy_change_flag_set_o);
    chk(16'(cnt), 16'(e));
    rchk(PLM_LINK_IDX, 16'h0020);
    rchk(PLM_MODE_IDX, {14'h0010, e, 1'b0});
  endtask
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    sw_reset_i = 1'b0;
    line_energy_i = 1'b1;
    adv_next_page_i = 1'b0;
    manual_mdix_i = 2'b10;
    auto_mdix_i = 2'b01;
    repeat (12) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_defaults();
    t_freeze();
    t_speed();
    t_all_ones();
    t_hwreset();
    t_swreset(1'b1);
    t_swreset(1'b0);
    complete_run();
  end
endmodule
